//--- hdl/crf_regs.vh
// Register offsets, field positions, reset values and timing counts for the comparator result block
`ifndef CRF_REGS_VH
`define CRF_REGS_VH
// ****************************************
// Register word offsets (word aligned index = offset, byte address = 4 x offset)
// ****************************************
`define CRF_OFS_CMP_CTRL 10'h01F8
`define CRF_OFS_EXT_EN 10'h01FA
`define CRF_OFS_FILT_SEL 10'h01FC
`define CRF_OFS_IRQ_CTRL1 10'h0200
`define CRF_OFS_IRQ_CTRL3 10'h0201
`define CRF_OFS_IRQ_STAT 10'h0202
`define CRF_OFS_IRQ_MASK 10'h0203
// ****************************************
// Field positions
// ****************************************
`define CRF_BIT_RUN1 0
`define CRF_BIT_MON1 3
`define CRF_BIT_RUN3 4
`define CRF_BIT_MON3 7
`define CRF_BIT_EN1 2
`define CRF_BIT_PL1 3
`define CRF_BIT_EN3 6
`define CRF_BIT_PL3 7
`define CRF_IC_LVL_LO 0
`define CRF_IC_LVL_HI 2
`define CRF_IC_REQ 3
`define CRF_IC_POL 4
// ****************************************
// Reset values and codes
// ****************************************
`define CRF_RST_BYTE 8'h00
`define CRF_CTRL_WMASK 8'h11
`define CRF_IC_WMASK 8'h17
`define CRF_FILT_NONE 2'h0
`define CRF_FILT_F1 2'h1
`define CRF_FILT_F8 2'h2
`define CRF_FILT_F32 2'h3
`define CRF_DIV_F8 3'h7
`define CRF_DIV_F32 5'h1F
`define CRF_MATCH_COUNT 2'h3
`endif

//--- hdl/crf_sync.v
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module crf_sync
(
    // System
    input wire clk_in,
    input wire rst_n_in,
    // Data
    input wire async_in,
    output reg sync_out
);
    reg stage1;

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

//--- hdl/crf_channel.v
// One comparator channel: monitor level, three-sample filter and edge request
`timescale 1ns/10ps
`include "crf_regs.vh"
module crf_channel
(
    // System
    input wire clk_in,
    input wire rst_n_in,
    // Comparator and sampling ticks
    input wire cmp_sync_in,
    input wire run_in,
    input wire tick_f1_in,
    input wire tick_f8_in,
    input wire tick_f32_in,
    // Configuration
    input wire [1:0] filt_sel_in,
    input wire irq_en_in,
    input wire both_edges_in,
    input wire pol_rising_in,
    // Results
    output reg monitor_out,
    output reg req_out
);
    reg filt_level;
    reg [1:0] match_cnt;
    reg last_sample;
    reg prev_level;
    reg tick;
    wire level;
    wire cmp_gated;
    wire rise;
    wire fall;

    // Disabled channel reads and feeds zero
    assign cmp_gated = cmp_sync_in & run_in;

    always @*
    begin
        case (filt_sel_in)
            `CRF_FILT_F1: tick = tick_f1_in;
            `CRF_FILT_F8: tick = tick_f8_in;
            `CRF_FILT_F32: tick = tick_f32_in;
            default: tick = 1'b0;
        endcase
    end

    // Unfiltered path goes straight to edge detection
    assign level = (filt_sel_in == `CRF_FILT_NONE) ? cmp_gated : filt_level;
    assign rise = level & ~prev_level;
    assign fall = ~level & prev_level;

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            filt_level <= 1'b0;
            match_cnt <= 2'h0;
            last_sample <= 1'b0;
            prev_level <= 1'b0;
            monitor_out <= 1'b0;
            req_out <= 1'b0;
        end
        else
        begin
            monitor_out <= cmp_gated;
            if (tick)
            begin
                last_sample <= cmp_gated;
                if (cmp_gated != last_sample)
                begin
                    match_cnt <= 2'h1;
                end
                else if (match_cnt != `CRF_MATCH_COUNT)
                begin
                    match_cnt <= match_cnt + 2'h1;
                end
                if (cmp_gated == last_sample && match_cnt == 2'h2)
                begin
                    filt_level <= cmp_gated;
                end
            end
            prev_level <= level;
            // Edge chosen by edge count and direction together
            req_out <= irq_en_in & (both_edges_in ? (rise | fall) : (pol_rising_in ? rise : fall));
        end
    end
endmodule

//--- hdl/crf_top.v
// Comparator result filter and interrupt block with Avalon-MM register slave
// Function
// - Two identical independent channels, 1 and 3, each with own path.
// - Enabled channel monitor flag reads 1 above reference, 0 below.
// - Monitor flag reads 0 while channel disabled; flag is read-only.
// - Control register bit 0 enables channel 1, bit 4 channel 3.
// - Monitor flags at control bits 3 and 7; other bits reserved zero.
// - Even bits of input enable register enable each input's request.
// - Odd bits select one edge (0) or both edges (1).
// - Rewriting input enable register may set the request flag.
// - Filter field per input: none, f1, f8 or f32 sampling.
// - Filter sets request only after three matching consecutive samples.
// - Enabled channel requests on each result change, per polarity.
// - Channel shares request flag and level bits with input.
// - Request edge set by edge count and direction bits together.
`timescale 1ns/10ps
`include "crf_regs.vh"
module crf_top
(
    // System
    input wire clk_in,
    input wire rst_n_in,
    // Comparator outputs from the analog side
    input wire cmp1_in,
    input wire cmp3_in,
    // Avalon-MM slave
    input wire [11:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    // Interrupt
    output reg irq_out,
    output reg [2:0] priority_level1_out,
    output reg [2:0] priority_level3_out
);
    // ****************************************
    // Reset release and synchronisers
    // ****************************************
    reg rst_meta;
    reg rst_sync_n;
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    wire cmp1_sync;
    wire cmp3_sync;
    // Analog outputs are asynchronous to clk_in
    crf_sync u_sync1
    (
        .clk_in(clk_in),
        .rst_n_in(rst_sync_n),
        .async_in(cmp1_in),
        .sync_out(cmp1_sync)
    );
    crf_sync u_sync3
    (
        .clk_in(clk_in),
        .rst_n_in(rst_sync_n),
        .async_in(cmp3_in),
        .sync_out(cmp3_sync)
    );

    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] comparator_control;
    reg [7:0] external_input_enable;
    reg [7:0] input_filter_select;
    reg [7:0] irq_control_reg1;
    reg [7:0] irq_control_reg3;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg [4:0] prescale;
    reg tick_f8;
    reg tick_f32;
    reg pending;
    wire mon1;
    wire mon3;
    wire req1;
    wire req3;
    wire [9:0] word_idx;
    wire acc;
    wire wr_lane0;
    wire wr_ev;
    wire en_write;
    reg [7:0] rd_byte;
    reg hit;

    assign word_idx = avs_address_in[11:2];
    assign acc = avs_read_in | avs_write_in;
    // One wait state: request taken on the second edge
    assign wr_ev = avs_write_in & pending & avs_byteenable_in[0];
    assign wr_lane0 = wr_ev;
    assign en_write = wr_lane0 && word_idx == `CRF_OFS_EXT_EN;

    // ****************************************
    // Sampling clock prescaler
    // ****************************************
    always @(posedge clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            prescale <= 5'h00;
            tick_f8 <= 1'b0;
            tick_f32 <= 1'b0;
        end
        else
        begin
            prescale <= prescale + 5'h01;
            tick_f8 <= (prescale[2:0] == `CRF_DIV_F8) ? 1'b1 : 1'b0;
            tick_f32 <= (prescale == `CRF_DIV_F32) ? 1'b1 : 1'b0;
        end
    end

    // ****************************************
    // Channels
    // ****************************************
    crf_channel u_ch1
    (
        .clk_in(clk_in),
        .rst_n_in(rst_sync_n),
        .cmp_sync_in(cmp1_sync),
        .run_in(comparator_control[`CRF_BIT_RUN1]),
        .tick_f1_in(1'b1),
        .tick_f8_in(tick_f8),
        .tick_f32_in(tick_f32),
        .filt_sel_in(input_filter_select[3:2]),
        .irq_en_in(external_input_enable[`CRF_BIT_EN1]),
        .both_edges_in(external_input_enable[`CRF_BIT_PL1]),
        .pol_rising_in(irq_control_reg1[`CRF_IC_POL]),
        .monitor_out(mon1),
        .req_out(req1)
    );
    crf_channel u_ch3
    (
        .clk_in(clk_in),
        .rst_n_in(rst_sync_n),
        .cmp_sync_in(cmp3_sync),
        .run_in(comparator_control[`CRF_BIT_RUN3]),
        .tick_f1_in(1'b1),
        .tick_f8_in(tick_f8),
        .tick_f32_in(tick_f32),
        .filt_sel_in(input_filter_select[7:6]),
        .irq_en_in(external_input_enable[`CRF_BIT_EN3]),
        .both_edges_in(external_input_enable[`CRF_BIT_PL3]),
        .pol_rising_in(irq_control_reg3[`CRF_IC_POL]),
        .monitor_out(mon3),
        .req_out(req3)
    );

    // ****************************************
    // Read mux
    // ****************************************
    always @*
    begin
        rd_byte = `CRF_RST_BYTE;
        hit = 1'b1;
        case (word_idx)
            `CRF_OFS_CMP_CTRL: rd_byte = {mon3, 2'h0, comparator_control[4], mon1, 2'h0,
                comparator_control[0]};
            `CRF_OFS_EXT_EN: rd_byte = external_input_enable;
            `CRF_OFS_FILT_SEL: rd_byte = input_filter_select;
            `CRF_OFS_IRQ_CTRL1: rd_byte = irq_control_reg1;
            `CRF_OFS_IRQ_CTRL3: rd_byte = irq_control_reg3;
            `CRF_OFS_IRQ_STAT: rd_byte = {6'h00, irq_status};
            `CRF_OFS_IRQ_MASK: rd_byte = {6'h00, irq_mask};
            default: hit = 1'b0;
        endcase
    end

    // ****************************************
    // Register decode
    // ****************************************
    wire wr_ctl;
    wire wr_flt;
    wire wr_ic1;
    wire wr_ic3;
    wire wr_sts;
    wire wr_msk;

    assign wr_ctl = wr_lane0 && word_idx == `CRF_OFS_CMP_CTRL;
    assign wr_flt = wr_lane0 && word_idx == `CRF_OFS_FILT_SEL;
    assign wr_ic1 = wr_lane0 && word_idx == `CRF_OFS_IRQ_CTRL1;
    assign wr_ic3 = wr_lane0 && word_idx == `CRF_OFS_IRQ_CTRL3;
    assign wr_sts = wr_lane0 && word_idx == `CRF_OFS_IRQ_STAT;
    assign wr_msk = wr_lane0 && word_idx == `CRF_OFS_IRQ_MASK;

    // ****************************************
    // Bus handshake
    // ****************************************
    always @(posedge clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pending <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end
        else
        begin
            // Waitrequest drops for exactly one cycle, then the master releases
            pending <= acc & ~pending;
            avs_waitrequest_out <= ~(acc & ~pending);
            if (avs_read_in & ~pending)
            begin
                avs_readdata_out <= {24'h00_0000, hit ? rd_byte : 8'h00};
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always @(posedge clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            comparator_control <= `CRF_RST_BYTE;
        end
        else if (wr_ctl)
        begin
            // Reserved and monitor positions are never stored
            comparator_control <= avs_writedata_in[7:0] & `CRF_CTRL_WMASK;
        end
    end

    always @(posedge clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            external_input_enable <= `CRF_RST_BYTE;
        end
        else if (en_write)
        begin
            external_input_enable <= avs_writedata_in[7:0];
        end
    end

    always @(posedge clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            input_filter_select <= `CRF_RST_BYTE;
        end
        else if (wr_flt)
        begin
            input_filter_select <= avs_writedata_in[7:0];
        end
    end

    always @(posedge clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            irq_mask <= 2'h0;
        end
        else if (wr_msk)
        begin
            irq_mask <= avs_writedata_in[1:0];
        end
    end

    // ****************************************
    // Interrupt control registers
    // ****************************************
    // Channel request and a rewritten enable share the input's flag; set beats clear
    always @(posedge clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            irq_control_reg1 <= `CRF_RST_BYTE;
        end
        else
        begin
            if (wr_ic1)
            begin
                irq_control_reg1 <= avs_writedata_in[7:0] & `CRF_IC_WMASK;
            end
            if (req1 | (en_write & avs_writedata_in[`CRF_BIT_EN1]))
            begin
                irq_control_reg1[`CRF_IC_REQ] <= 1'b1;
            end
        end
    end

    always @(posedge clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            irq_control_reg3 <= `CRF_RST_BYTE;
        end
        else
        begin
            if (wr_ic3)
            begin
                irq_control_reg3 <= avs_writedata_in[7:0] & `CRF_IC_WMASK;
            end
            if (req3 | (en_write & avs_writedata_in[`CRF_BIT_EN3]))
            begin
                irq_control_reg3[`CRF_IC_REQ] <= 1'b1;
            end
        end
    end

    // ****************************************
    // Interrupt status and outputs
    // ****************************************
    always @(posedge clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            irq_status <= 2'h0;
            irq_out <= 1'b0;
            priority_level1_out <= 3'h0;
            priority_level3_out <= 3'h0;
        end
        else
        begin
            // An event in the cycle of its clear keeps the bit set
            if (req1)
            begin
                irq_status[0] <= 1'b1;
            end
            else if (wr_sts && avs_writedata_in[0])
            begin
                irq_status[0] <= 1'b0;
            end
            if (req3)
            begin
                irq_status[1] <= 1'b1;
            end
            else if (wr_sts && avs_writedata_in[1])
            begin
                irq_status[1] <= 1'b0;
            end
            irq_out <= |(irq_status & irq_mask);
            priority_level1_out <= irq_control_reg1[`CRF_IC_LVL_HI:`CRF_IC_LVL_LO];
            priority_level3_out <= irq_control_reg3[`CRF_IC_LVL_HI:`CRF_IC_LVL_LO];
        end
    end
endmodule

//--- testbench/crf_analog_model.sv
// Behavioural analog front end: two comparators fed with level codes
`timescale 1ns/10ps
module crf_analog_model
(
    // Analog levels as codes
    input wire [11:0] vin1_in,
    input wire [11:0] vref1_in,
    input wire [11:0] vin3_in,
    input wire [11:0] vref3_in,
    // Comparator outputs
    output wire cmp1_out,
    output wire cmp3_out
);
// ********
// Comparison
// ********
// Equal levels resolve low; a real comparator is undecided there
assign cmp1_out = vin1_in > vref1_in;
assign cmp3_out = vin3_in > vref3_in;
endmodule

//--- testbench/crf_top_monitor.sv
// Port checker for the comparator result block
`timescale 1ns/10ps
`include "crf_regs.vh"
module crf_top_monitor
(
    // System
    input wire clk_in,
    input wire rst_n_in,
    // Comparators
    input wire cmp1_in,
    input wire cmp3_in,
    // Avalon-MM slave
    input wire [11:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_writedata_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    // Interrupt
    input wire irq_out,
    input wire [2:0] priority_level1_out,
    input wire [2:0] priority_level3_out
);
// ********
// Shadow of written fields
// ********
reg run1;
reg run3;
reg [2:0] lvl1;
reg [2:0] lvl3;
wire [9:0] idx = avs_address_in[11:2];
wire req = avs_read_in | avs_write_in;
wire rac = avs_read_in & ~avs_waitrequest_out;
wire wac = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
wire mapped = idx == `CRF_OFS_CMP_CTRL || idx == `CRF_OFS_EXT_EN || idx == `CRF_OFS_FILT_SEL ||
    (idx >= `CRF_OFS_IRQ_CTRL1 && idx <= `CRF_OFS_IRQ_MASK);
always @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
        {run1, run3, lvl1, lvl3} <= 8'h00;
    else if (wac)
    begin
        if (idx == `CRF_OFS_CMP_CTRL)
            {run3, run1} <= {avs_writedata_in[4], avs_writedata_in[0]};
        if (idx == `CRF_OFS_IRQ_CTRL1)
            lvl1 <= avs_writedata_in[2:0];
        if (idx == `CRF_OFS_IRQ_CTRL3)
            lvl3 <= avs_writedata_in[2:0];
    end
end
default clocking @(posedge clk_in); endclocking
default disable iff (!rst_n_in);
a_wait_single: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out) else $error("wait low too long");
a_wait_cause: assert property (!avs_waitrequest_out |-> $past(req)) else $error("answer without request");
a_idle_hold: assert property (!req |=> avs_waitrequest_out) else $error("answer while idle");
a_answer_bound: assert property (req |-> ##[0:3] !avs_waitrequest_out) else $error("no answer");
a_read_upper: assert property (rac |-> avs_readdata_out[31:8] == 24'h00_0000) else $error("upper bits set");
a_unmapped_zero: assert property (rac && !mapped |-> avs_readdata_out[7:0] == 8'h00) else $error("unmapped read");
a_ctrl_fields: assert property (rac && idx == `CRF_OFS_CMP_CTRL |-> avs_readdata_out[0] == run1 &&
    avs_readdata_out[4] == run3 && avs_readdata_out[2:1] == 2'h0 && avs_readdata_out[6:5] == 2'h0)
    else $error("control fields wrong");
a_level_one: assert property (wac && idx == `CRF_OFS_IRQ_CTRL1 |=> ##[0:1] priority_level1_out == lvl1)
    else $error("level 1 not copied");
a_level_three: assert property (wac && idx == `CRF_OFS_IRQ_CTRL3 |=> ##[0:1] priority_level3_out == lvl3)
    else $error("level 3 not copied");
a_mask_quiet: assert property (wac && idx == `CRF_OFS_IRQ_MASK && avs_writedata_in[1:0] == 2'h0 |-> ##[1:3] !irq_out)
    else $error("masked irq stays high");
c_read: cover property (rac && idx == `CRF_OFS_CMP_CTRL);
c_irq: cover property ($rose(irq_out));
c_mask: cover property (wac && idx == `CRF_OFS_IRQ_MASK);
endmodule
bind crf_top crf_top_monitor u_crf_top_monitor (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmp1_in(cmp1_in),
    .cmp3_in(cmp3_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .priority_level1_out(priority_level1_out),
    .priority_level3_out(priority_level3_out));

//--- testbench/crf_top_bench.sv
// Self-checking bench for the comparator result block
`timescale 1ns/10ps
`include "crf_regs.vh"
module crf_top_bench;
// ********
// Stimulus
// ********
localparam [9:0] ctl = `CRF_OFS_CMP_CTRL;
localparam [9:0] ext = `CRF_OFS_EXT_EN;
localparam [9:0] flt = `CRF_OFS_FILT_SEL;
localparam [9:0] ic1 = `CRF_OFS_IRQ_CTRL1;
localparam [9:0] ic3 = `CRF_OFS_IRQ_CTRL3;
localparam [9:0] sts = `CRF_OFS_IRQ_STAT;
localparam [9:0] msk = `CRF_OFS_IRQ_MASK;
reg clk_in = 1'b0;
reg rst_n_in = 1'b0;
reg [11:0] adr = 12'h000;
reg rd_q = 1'b0;
reg wr_q = 1'b0;
reg [3:0] be = 4'hF;
reg [31:0] wd = 32'h0000_0000;
reg [11:0] vin1 = 12'h032;
reg [11:0] vin3 = 12'h032;
wire cmp1;
wire cmp3;
wire [31:0] rdata;
wire wait_q;
wire irq;
wire [2:0] lvl1;
wire [2:0] lvl3;
integer fail_count = 0;
integer samples_checked = 0;
integer cycles = 0;
integer k;
integer d;
reg [25:0] rows [0:8] = '{{ctl, 8'hFF, 8'h11}, {ctl, 8'h00, 8'h00}, {flt, 8'hFF, 8'hFF}, {flt, 8'h00, 8'h00},
    {ext, 8'hA5, 8'hA5}, {ext, 8'h00, 8'h00}, {msk, 8'h03, 8'h03}, {msk, 8'h00, 8'h00}, {10'h1F9, 8'hFF, 8'h00}};
crf_analog_model u_crf_analog_model (.vin1_in(vin1), .vref1_in(12'h064), .vin3_in(vin3), .vref3_in(12'h064),
    .cmp1_out(cmp1), .cmp3_out(cmp3));
crf_top u_crf_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmp1_in(cmp1), .cmp3_in(cmp3), .avs_address_in(adr),
    .avs_read_in(rd_q), .avs_write_in(wr_q), .avs_byteenable_in(be), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_q), .irq_out(irq), .priority_level1_out(lvl1), .priority_level3_out(lvl3));
always #50 clk_in = ~clk_in;
task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
// Whole run needs under two thousand cycles; a hang is cut here
always @(posedge clk_in)
begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
        fail_count = fail_count + 1;
        end_sim;
    end
end
task chk(input string nm, input [7:0] seen, input [7:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
        fail_count = fail_count + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
endtask
task tk(input integer n);
    repeat (n) @(posedge clk_in);
endtask
// Request held until waitrequest is seen low, then one idle cycle
task bus(input [9:0] i, input w, input [7:0] dv, output [7:0] q);
    adr <= {i, 2'b00};
    wr_q <= w;
    rd_q <= ~w;
    wd <= {24'h00_0000, dv};
    @(posedge clk_in);
    while (wait_q !== 1'b0) @(posedge clk_in);
    q = rdata[7:0];
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    @(posedge clk_in);
endtask
task wr(input [9:0] i, input [7:0] dv);
    reg [7:0] q;
    bus(i, 1'b1, dv, q);
endtask
task rd(input string nm, input [9:0] i, input [7:0] e);
    reg [7:0] q;
    bus(i, 1'b0, 8'h00, q);
    chk(nm, q, e);
endtask
initial
begin
    tk(3);
    rst_n_in <= 1'b1;
    tk(4);
    rd("ctl_rst", ctl, 8'h00);
    rd("ext_rst", ext, 8'h00);
    $display("test reset done");
    for (k = 0; k < 9; k = k + 1)
    begin
        wr(rows[k][25:16], rows[k][15:8]);
        rd("row", rows[k][25:16], rows[k][7:0]);
    end
    be <= 4'h0;
    wr(msk, 8'h03);
    be <= 4'hF;
    rd("lane_off", msk, 8'h00);
    $display("test registers done");
    vin1 <= 12'h0C8;
    wr(ctl, 8'h11);
    tk(8);
    rd("mon_a", ctl, 8'h19);
    vin1 <= 12'h032;
    vin3 <= 12'h0C8;
    tk(8);
    rd("mon_b", ctl, 8'h91);
    vin1 <= 12'h0C8;
    wr(ctl, 8'h10);
    tk(8);
    rd("mon_off", ctl, 8'h90);
    $display("test monitor done");
    wr(ctl, 8'h11);
    // Comparator settles before its interrupt path is touched
    tk(1000);
    wr(ic1, 8'h15);
    wr(ext, 8'h04);
    rd("ic1_spur", ic1, 8'h1D);
    tk(8);
    wr(sts, 8'h03);
    wr(ic1, 8'h15);
    wr(msk, 8'h01);
    tk(3);
    chk("irq_idle", {7'h00, irq}, 8'h00);
    chk("lvl1", {5'h00, lvl1}, 8'h05);
    vin1 <= 12'h032;
    tk(8);
    chk("irq_fall", {7'h00, irq}, 8'h00);
    vin1 <= 12'h0C8;
    tk(8);
    chk("irq_rise", {7'h00, irq}, 8'h01);
    rd("sts_rise", sts, 8'h01);
    rd("ic1_flag", ic1, 8'h1D);
    wr(sts, 8'h01);
    tk(3);
    chk("irq_clr", {7'h00, irq}, 8'h00);
    // Falling direction set first; with both edges chosen the direction bit is ignored
    wr(ic1, 8'h05);
    wr(ext, 8'h0C);
    tk(8);
    wr(sts, 8'h03);
    vin1 <= 12'h032;
    tk(8);
    chk("both_fall", {7'h00, irq}, 8'h01);
    wr(sts, 8'h01);
    vin1 <= 12'h0C8;
    tk(8);
    chk("both_rise", {7'h00, irq}, 8'h01);
    wr(msk, 8'h00);
    wr(sts, 8'h01);
    vin1 <= 12'h032;
    tk(8);
    chk("masked", {7'h00, irq}, 8'h00);
    rd("sts_masked", sts, 8'h01);
    $display("test edges done");
    wr(ext, 8'h40);
    wr(ic3, 8'h13);
    vin3 <= 12'h032;
    wr(msk, 8'h02);
    // Pulse spans two samples at most, held level spans four or more
    for (k = 1; k < 4; k = k + 1)
    begin
        d = (k == 1) ? 1 : (k == 2) ? 8 : 32;
        wr(flt, {k[1:0], 6'h00});
        tk(4 * d + 8);
        wr(sts, 8'h03);
        vin3 <= 12'h0C8;
        tk(2 * d - 1);
        vin3 <= 12'h032;
        tk(4 * d + 8);
        chk("pulse", {7'h00, irq}, 8'h00);
        vin3 <= 12'h0C8;
        tk(4 * d + 8);
        chk("held", {7'h00, irq}, 8'h01);
        vin3 <= 12'h032;
    end
    chk("lvl3", {5'h00, lvl3}, 8'h03);
    $display("test filter done");
    end_sim;
end
endmodule
